/* File: tcc_consts.svh */
/*
  constant definitions for the 16-bit counter with input capture:
  byte-location codes, waveform modes, fixed ceilings, filter length.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// byte location codes on the register port
`define TCC_LOC_COUNT_LOWER   3'h0
`define TCC_LOC_COUNT_UPPER   3'h1
`define TCC_LOC_CAPT_LOWER    3'h2
`define TCC_LOC_CAPT_UPPER    3'h3
`define TCC_LOC_CMPA_LOWER    3'h4
`define TCC_LOC_CMPA_UPPER    3'h5

// fixed ceilings
`define TCC_TOP_8BIT          16'h00ff
`define TCC_TOP_9BIT          16'h01ff
`define TCC_TOP_10BIT         16'h03ff
`define TCC_MAX               16'hffff
`define TCC_BOTTOM            16'h0000

// waveform mode codes
`define TCC_WGM_NORMAL        4'h0
`define TCC_WGM_PC8           4'h1
`define TCC_WGM_PC9           4'h2
`define TCC_WGM_PC10          4'h3
`define TCC_WGM_CTC_A         4'h4
`define TCC_WGM_F8            4'h5
`define TCC_WGM_F9            4'h6
`define TCC_WGM_F10           4'h7
`define TCC_WGM_PFC_C         4'h8
`define TCC_WGM_PFC_A         4'h9
`define TCC_WGM_PC_C          4'ha
`define TCC_WGM_PC_A          4'hb
`define TCC_WGM_CTC_C         4'hc
`define TCC_WGM_FAST_C        4'he
`define TCC_WGM_FAST_A        4'hf

// clock select value meaning no source
`define TCC_CS_NONE           3'h0

// noise filter length in samples
`define TCC_FILTER_LEN        4

// reset values
`define TCC_RESET_WORD        16'h0000
`define TCC_RESET_BYTE        8'h00

`endif

/* File: tcc_cpu_model.sv */
/* processor model: byte writes and reads on the timer port.
   assumes the bench calls its tasks; strobes move at the falling edge. */
module tcc_cpu_model (
  // clock
  input wire logic       clk,
  // byte port
  output logic [2:0]     bus_loc,
  output logic           bus_wr,
  output logic           bus_rd,
  output logic [7:0]     bus_wdata,
  input wire logic [7:0] bus_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    bus_loc = 3'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end
  // one byte, strobe for one edge; data then goes stale
  task automatic wr8(input logic [2:0] loc, input logic [7:0] d);
    @(negedge clk);
    bus_loc = loc;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask
  // upper byte first, lower after gap+1 idle cycles
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v, input int gap);
    wr8(lo + 3'h1, v[15:8]);
    repeat (gap) @(negedge clk);
    wr8(lo, v[7:0]);
  endtask
  // lower byte then upper byte back to back
  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    @(negedge clk);
    bus_loc = lo;
    bus_rd = 1'b1;
    @(negedge clk);
    v[7:0] = bus_rdata_q;
    bus_loc = lo + 3'h1;
    @(negedge clk);
    v[15:8] = bus_rdata_q;
    bus_rd = 1'b0;
  endtask
endmodule

/* File: tcc_filter.sv */
/*
  four-sample noise filter and edge detector for the capture path.
  assumes the source input is synchronous to clk; bypassed when disabled.
*/
`include "tcc_consts.svh"

module tcc_filter #(
  parameter int LEN = `TCC_FILTER_LEN
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic enable,
  input  wire logic filter_en,
  input  wire logic rising_sel,
  // source and event
  input  wire logic src_in,
  output logic      edge_q
);
  logic [LEN-2:0] hist_q;  // earlier samples; the newest is src_in itself
  logic [LEN-1:0] win;     // sample window ending with this cycle's input
  logic           filt_q;  // filtered level
  logic           prev_q;  // level seen by edge detector last cycle
  logic           lvl;     // level fed to edge detector

  // shift in samples on every system clock
  always_ff @(posedge clk) begin
    if (rst) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[LEN-3:0], src_in};
    end
  end

  // window includes the live sample, so the filter adds exactly LEN cycles
  assign win = {hist_q, src_in};

  // output moves only once all samples agree
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= 1'b0;
    end else if (&win) begin
      filt_q <= 1'b1;
    end else if (~|win) begin
      filt_q <= 1'b0;
    end
  end

  // filter adds its delay ahead of the detector only when enabled
  assign lvl = filter_en ? filt_q : src_in;

  // previous level for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lvl;
    end
  end

  // edge of chosen polarity, gated off in capture-ceiling modes
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_q <= 1'b0;
    end else begin
      edge_q <= enable & (rising_sel ? (lvl & ~prev_q) : (~lvl & prev_q));
    end
  end
endmodule

/* File: tcc_pkg.sv */
/*
  types for the 16-bit counter with input capture.
  assumes tcc_consts.svh sits beside it.
*/
`include "tcc_consts.svh"

package tcc_pkg;
  // counting direction
  typedef enum logic [0:0] {
    TCC_DIR_UP   = 1'b0,
    TCC_DIR_DOWN = 1'b1
  } tcc_dir_t;

  // what the counter does on a tick
  typedef enum logic [1:0] {
    TCC_ACT_HOLD = 2'b00,
    TCC_ACT_INC  = 2'b01,
    TCC_ACT_DEC  = 2'b10,
    TCC_ACT_CLR  = 2'b11
  } tcc_act_t;
endpackage

/* File: tcc_timer.sv */
/*
  16-bit up/down counter with input capture and shared upper-byte holding
  register, reached byte-wise over an 8-bit processor port.
  assumes a single system clock, synchronous inputs, and a one-cycle
  timer_tick pulse from an outside prescaler or external count pin.
*/
// How it works
// - clock select zero halts the counter
// - step by one per tick; clear zeroes
// - ceiling flag at mode top, floor at zero
// - count/capture lower read latches upper; upper writes and count/capture upper reads hit holding
// - counter write loads upper from holding immediately
// - processor write beats clear and count
// - counter readable and writable while halted
// - tick clears, increments or decrements per mode
// - overflow flag set per mode, drives request
// - matching capture edge copies full count
// - capture flag set with capture copy
// - enabled flag requests irq; cleared on service
// - writing one clears capture flag
// - capture lower read first latches upper
// - capture writable only in capture-ceiling modes
// - source is pin, comparator when selected
// - source switch may capture; software clears flag
// - filter adds four system cycles of delay
// - capture inputs active except capture-ceiling modes
// - ceiling fixed, compare A or capture value
// - one holding register shared by all words
// - filter changes after four equal samples
// - upper first; lower write loads whole word
`include "tcc_consts.svh"

module tcc_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // processor byte port
  input  wire logic [2:0] bus_loc,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata_q,
  // control bits
  input  wire logic [2:0] clock_source_select,
  input  wire logic [3:0] waveform_mode_select,
  input  wire logic       capture_noise_filter_enable,
  input  wire logic       capture_edge_rising,
  input  wire logic       comparator_capture_select,
  input  wire logic       capture_irq_enable,
  input  wire logic       overflow_irq_enable,
  input  wire logic       capture_flag_clear,
  input  wire logic       overflow_flag_clear,
  input  wire logic       capture_irq_ack,
  input  wire logic       overflow_irq_ack,
  // tick and capture sources
  input  wire logic       timer_tick,
  input  wire logic       capture_input_pin,
  input  wire logic       comparator_output,
  // status
  output logic [15:0]     timer_count_q,
  output logic [15:0]     capture_value_q,
  output logic            count_top_q,
  output logic            count_bottom_q,
  output logic            count_overflow_flag_q,
  output logic            capture_event_flag_q,
  output logic            capture_irq_q,
  output logic            overflow_irq_q
);
  logic [7:0]       hold_q;       // shared upper-byte holding register
  logic [15:0]      cmpa_q;       // compare value a
  logic [15:0]      top;          // ceiling for current mode
  logic             cap_ceiling;  // mode uses capture value as ceiling
  logic             dual_slope;   // phase-correct style modes
  tcc_pkg::tcc_dir_t dir_q;       // counting direction
  tcc_pkg::tcc_act_t act;         // counter action this tick
  logic             tick_en;      // gated tick
  logic             cnt_wr;       // processor writes counter
  logic             cap_wr;       // processor writes capture lower
  logic             cap_edge;     // capture event from filter
  logic             cap_src;      // chosen capture source
  logic             ovf_set;      // overflow event

  // mode decode: ceiling selection
  always_comb begin
    cap_ceiling = 1'b0;
    dual_slope  = 1'b0;
    top         = `TCC_MAX;
    case (waveform_mode_select)
      `TCC_WGM_NORMAL: top = `TCC_MAX;
      `TCC_WGM_PC8: begin
        top        = `TCC_TOP_8BIT;
        dual_slope = 1'b1;
      end
      `TCC_WGM_PC9: begin
        top        = `TCC_TOP_9BIT;
        dual_slope = 1'b1;
      end
      `TCC_WGM_PC10: begin
        top        = `TCC_TOP_10BIT;
        dual_slope = 1'b1;
      end
      `TCC_WGM_CTC_A:  top = cmpa_q;
      `TCC_WGM_F8:     top = `TCC_TOP_8BIT;
      `TCC_WGM_F9:     top = `TCC_TOP_9BIT;
      `TCC_WGM_F10:    top = `TCC_TOP_10BIT;
      `TCC_WGM_PFC_C, `TCC_WGM_PC_C: begin
        top         = capture_value_q;
        cap_ceiling = 1'b1;
        dual_slope  = 1'b1;
      end
      `TCC_WGM_PFC_A, `TCC_WGM_PC_A: begin
        top        = cmpa_q;
        dual_slope = 1'b1;
      end
      `TCC_WGM_CTC_C, `TCC_WGM_FAST_C: begin
        top         = capture_value_q;
        cap_ceiling = 1'b1;
      end
      `TCC_WGM_FAST_A: top = cmpa_q;
      default:         top = `TCC_MAX;
    endcase
  end

  // tick only counts when a source is selected
  assign tick_en = timer_tick & (clock_source_select != `TCC_CS_NONE);
  assign cnt_wr  = bus_wr & (bus_loc == `TCC_LOC_COUNT_LOWER);
  // capture writes accepted only in capture-ceiling modes
  assign cap_wr  = bus_wr & (bus_loc == `TCC_LOC_CAPT_LOWER) & cap_ceiling;

  // single-slope modes wrap to zero on the ceiling; dual-slope modes turn
  // per-tick action from mode and direction
  always_comb begin
    act = tcc_pkg::TCC_ACT_HOLD;
    if (tick_en) begin
      if (dual_slope) begin
        act = (dir_q == tcc_pkg::TCC_DIR_UP) ? tcc_pkg::TCC_ACT_INC : tcc_pkg::TCC_ACT_DEC;
      end else if (timer_count_q == top) begin
        act = tcc_pkg::TCC_ACT_CLR;
      end else begin
        act = tcc_pkg::TCC_ACT_INC;
      end
    end
  end

  // a lower-byte write lands whatever the tick does, so software never
  // has to stop the clock to set a new count
  // counter: write first, then clear/step by one
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_count_q <= `TCC_RESET_WORD;
    end else if (cnt_wr) begin
      timer_count_q <= {hold_q, bus_wdata};
    end else begin
      case (act)
        tcc_pkg::TCC_ACT_INC: timer_count_q <= timer_count_q + 16'h0001;
        tcc_pkg::TCC_ACT_DEC: timer_count_q <= timer_count_q - 16'h0001;
        tcc_pkg::TCC_ACT_CLR: timer_count_q <= `TCC_BOTTOM;
        default:              timer_count_q <= timer_count_q;
      endcase
    end
  end

  // direction is judged one step ahead so the counter turns on the ceiling
  // and on zero without overshooting; single-slope modes always count up
  // direction turns at top and bottom in dual-slope modes
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= tcc_pkg::TCC_DIR_UP;
    end else if (!dual_slope) begin
      dir_q <= tcc_pkg::TCC_DIR_UP;
    end else if (tick_en && !cnt_wr) begin
      if (timer_count_q + 16'h0001 >= top && dir_q == tcc_pkg::TCC_DIR_UP) begin
        dir_q <= tcc_pkg::TCC_DIR_DOWN;
      end else if (timer_count_q == 16'h0001 && dir_q == tcc_pkg::TCC_DIR_DOWN) begin
        dir_q <= tcc_pkg::TCC_DIR_UP;
      end
    end
  end

  // registered, so both flags trail the count by one clock
  // ceiling and floor indications
  always_ff @(posedge clk) begin
    if (rst) begin
      count_top_q    <= 1'b0;
      count_bottom_q <= 1'b1;
    end else begin
      count_top_q    <= (timer_count_q == top);
      count_bottom_q <= (timer_count_q == `TCC_BOTTOM);
    end
  end

  // overflow point: max in normal, bottom in dual slope, top otherwise
  always_comb begin
    if (waveform_mode_select == `TCC_WGM_NORMAL) begin
      ovf_set = tick_en & ~cnt_wr & (timer_count_q == `TCC_MAX);
    end else if (dual_slope) begin
      ovf_set = tick_en & ~cnt_wr & (act == tcc_pkg::TCC_ACT_DEC) & (timer_count_q == 16'h0001);
    end else begin
      ovf_set = tick_en & ~cnt_wr & (timer_count_q == top);
    end
  end

  // a clear landing in the same cycle as a new overflow must not lose it
  // overflow flag: set wins over clear or service
  always_ff @(posedge clk) begin
    if (rst) begin
      count_overflow_flag_q <= 1'b0;
    end else if (ovf_set) begin
      count_overflow_flag_q <= 1'b1;
    end else if (overflow_flag_clear || overflow_irq_ack) begin
      count_overflow_flag_q <= 1'b0;
    end
  end

  // capture source select
  assign cap_src = comparator_capture_select ? comparator_output : capture_input_pin;

  // filter and edge detector, disabled in capture-ceiling modes
  tcc_filter #(
    .LEN(`TCC_FILTER_LEN)
  ) u_filter (
    .clk        (clk),
    .rst        (rst),
    .enable     (~cap_ceiling),
    .filter_en  (capture_noise_filter_enable),
    .rising_sel (capture_edge_rising),
    .src_in     (cap_src),
    .edge_q     (cap_edge)
  );

  // a capture event beats a software load; in capture-ceiling modes the
  // detector is held off, so the two never meet in practice
  // capture register: copy count on event, or software load
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_value_q <= `TCC_RESET_WORD;
    end else if (cap_edge) begin
      capture_value_q <= timer_count_q;
    end else if (cap_wr) begin
      capture_value_q <= {hold_q, bus_wdata};
    end
  end

  // capture flag set with the copy, set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_event_flag_q <= 1'b0;
    end else if (cap_edge) begin
      capture_event_flag_q <= 1'b1;
    end else if (capture_flag_clear || capture_irq_ack) begin
      capture_event_flag_q <= 1'b0;
    end
  end

  // interrupt requests
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_irq_q  <= 1'b0;
      overflow_irq_q <= 1'b0;
    end else begin
      capture_irq_q  <= capture_irq_enable & (capture_event_flag_q | cap_edge) & ~capture_irq_ack;
      overflow_irq_q <= overflow_irq_enable & (count_overflow_flag_q | ovf_set) & ~overflow_irq_ack;
    end
  end

  // compare value a, loaded through the holding register
  always_ff @(posedge clk) begin
    if (rst) begin
      cmpa_q <= `TCC_RESET_WORD;
    end else if (bus_wr && bus_loc == `TCC_LOC_CMPA_LOWER) begin
      cmpa_q <= {hold_q, bus_wdata};
    end
  end

  // any upper-byte write or count/capture lower read overwrites this byte, so an
  // interrupt handler touching another word corrupts a split access
  // one shared holding register for every word
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= `TCC_RESET_BYTE;
    end else if (bus_wr && (bus_loc == `TCC_LOC_COUNT_UPPER || bus_loc == `TCC_LOC_CAPT_UPPER ||
                            bus_loc == `TCC_LOC_CMPA_UPPER)) begin
      hold_q <= bus_wdata;
    end else if (bus_rd && bus_loc == `TCC_LOC_COUNT_LOWER) begin
      hold_q <= timer_count_q[15:8];
    end else if (bus_rd && bus_loc == `TCC_LOC_CAPT_LOWER) begin
      hold_q <= capture_value_q[15:8];
    end
  end

  // compare a has no read latch: both of its bytes come straight out,
  // and the upper locations of count and capture return the held byte
  // read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata_q <= `TCC_RESET_BYTE;
    end else if (bus_rd) begin
      case (bus_loc)
        `TCC_LOC_COUNT_LOWER: bus_rdata_q <= timer_count_q[7:0];
        `TCC_LOC_CAPT_LOWER:  bus_rdata_q <= capture_value_q[7:0];
        `TCC_LOC_CMPA_LOWER:  bus_rdata_q <= cmpa_q[7:0];
        `TCC_LOC_CMPA_UPPER:  bus_rdata_q <= cmpa_q[15:8];
        `TCC_LOC_COUNT_UPPER: bus_rdata_q <= hold_q;
        `TCC_LOC_CAPT_UPPER:  bus_rdata_q <= hold_q;
        default:              bus_rdata_q <= `TCC_RESET_BYTE;
      endcase
    end
  end
endmodule

/* File: tcc_timer_sva.sv */
/* checker for tcc_timer, watching only its ports.
   assumes the bind at the foot attaches it to every tcc_timer. */
module tcc_timer_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // byte port
  input wire logic [2:0]  bus_loc,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata_q,
  // controls and tick
  input wire logic [2:0]  clock_source_select,
  input wire logic [3:0]  waveform_mode_select,
  input wire logic        capture_irq_enable,
  input wire logic        capture_irq_ack,
  input wire logic        timer_tick,
  // status
  input wire logic [15:0] timer_count_q,
  input wire logic [15:0] capture_value_q,
  input wire logic        count_bottom_q,
  input wire logic        count_overflow_flag_q,
  input wire logic        capture_event_flag_q,
  input wire logic        capture_irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       step;   // a tick that no write overrides
  logic       ceil;   // capture value used as ceiling
  logic [7:0] cnt_lo; // count lower byte
  logic [7:0] cnt_hi; // count upper byte
  assign step = timer_tick && clock_source_select != 3'h0 && !bus_wr;
  assign ceil = waveform_mode_select[3] && !waveform_mode_select[0];
  assign cnt_lo = timer_count_q[7:0];
  assign cnt_hi = timer_count_q[15:8];
  // lower then upper count read
  sequence s_rd_lo; bus_rd && bus_loc == 3'h0; endsequence
  sequence s_rd_hi; bus_rd && bus_loc == 3'h1; endsequence
  chk_halt_holds: assert property (clock_source_select == 3'h0 && !bus_wr |=> $stable(timer_count_q))
    else $error("count moved while halted");
  chk_step_one: assert property (step && waveform_mode_select == 4'h0 |=> timer_count_q == $past(timer_count_q) + 16'h1)
    else $error("count step wrong");
  chk_write_wins: assert property (bus_wr && bus_loc == 3'h0 |=> cnt_lo == $past(bus_wdata))
    else $error("count write lost");
  chk_bottom_flag: assert property (timer_count_q == 16'h0 |=> count_bottom_q)
    else $error("bottom flag missing");
  chk_ovf_set: assert property (step && waveform_mode_select == 4'h0 && timer_count_q == 16'hffff |=> count_overflow_flag_q && timer_count_q == 16'h0)
    else $error("overflow not flagged");
  chk_capt_copy: assert property ($rose(capture_event_flag_q) |-> capture_value_q == $past(timer_count_q))
    else $error("capture value not with flag");
  chk_no_capt: assert property (ceil [*8] |=> !$rose(capture_event_flag_q))
    else $error("capture in ceiling mode");
  chk_irq_req: assert property (capture_irq_enable && capture_event_flag_q && !capture_irq_ack |=> capture_irq_q)
    else $error("capture request missing");
  chk_read_lo: assert property (s_rd_lo |=> bus_rdata_q == $past(cnt_lo))
    else $error("lower read wrong");
  chk_read_hi: assert property (s_rd_lo ##1 s_rd_hi |=> bus_rdata_q == $past(cnt_hi, 2))
    else $error("held upper read wrong");
endmodule

bind tcc_timer tcc_timer_chk u_chk (.*);

/* File: timer16_counter_capture_tb.sv */
/* bench for tcc_timer: bus via the cpu model, controls at negedge.
   assumes tcc_timer, its checker and tcc_cpu_model compiled first. */
module timer16_counter_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // design signals, connected by name
  logic        clk, rst, bus_wr, bus_rd, timer_tick, capture_input_pin, comparator_output;
  logic        capture_noise_filter_enable, capture_edge_rising, comparator_capture_select;
  logic        capture_irq_enable, overflow_irq_enable, capture_flag_clear, overflow_flag_clear;
  logic        capture_irq_ack, overflow_irq_ack, count_top_q, count_bottom_q;
  logic        count_overflow_flag_q, capture_event_flag_q, capture_irq_q, overflow_irq_q;
  logic [2:0]  bus_loc, clock_source_select;
  logic [3:0]  waveform_mode_select;
  logic [7:0]  bus_wdata, bus_rdata_q;
  logic [15:0] timer_count_q, capture_value_q, v, r;
  logic [3:0]  modes [4] = '{4'h0, 4'h5, 4'h6, 4'h7}; // fixed-ceiling modes
  int          mismatches, samples_checked, n0, n1;

  tcc_timer u_dut (.*);
  tcc_cpu_model u_cpu (.*);

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ceiling of a fixed mode
  function automatic logic [15:0] top_of(input logic [3:0] m);
    case (m)
      4'h5: top_of = 16'h00ff;
      4'h6: top_of = 16'h01ff;
      4'h7: top_of = 16'h03ff;
      default: top_of = 16'hffff;
    endcase
  endfunction
  // one comparison, counted
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // software clear of the capture flag
  task automatic clr;
    @(negedge clk);
    capture_flag_clear = 1'b1;
    @(negedge clk);
    capture_flag_clear = 1'b0;
  endtask
  // pin rise after a long low; cycles until the flag shows
  task automatic lat(output int n);
    capture_input_pin = 1'b0;
    repeat (8) @(negedge clk);
    clr();
    capture_input_pin = 1'b1;
    n = 0;
    while (capture_event_flag_q !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    overflow_irq_enable = 1'b1;
    clock_source_select = 3'h0;
    waveform_mode_select = 4'h0;
    {capture_noise_filter_enable, capture_edge_rising, comparator_capture_select, capture_irq_enable,
     capture_flag_clear, overflow_flag_clear, capture_irq_ack, overflow_irq_ack, timer_tick,
     capture_input_pin, comparator_output} = '0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'hf736));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk("bottom at reset", 16'h1, {15'h0, count_bottom_q});
    // halted: random words round trip, ticks ignored
    repeat (6) begin
      v = 16'($urandom);
      u_cpu.wr16(3'h0, v, $urandom % 3);
      timer_tick = 1'b1;
      repeat (3) @(negedge clk);
      timer_tick = 1'b0;
      u_cpu.rd16(3'h0, r);
      chk("halted count", v, r);
    end
    // random ticks in normal mode
    clock_source_select = 3'h1;
    u_cpu.wr16(3'h0, 16'hf000, 0);
    n0 = 0;
    repeat (40) begin
      timer_tick = 1'($urandom);
      n0 += timer_tick;
      @(negedge clk);
    end
    timer_tick = 1'b0;
    chk("ticked count", 16'hf000 + 16'(n0), timer_count_q);
    // wrap at the maximum
    u_cpu.wr16(3'h0, 16'hffff, 0);
    timer_tick = 1'b1;
    @(negedge clk);
    timer_tick = 1'b0;
    @(negedge clk);
    chk("wrapped count", 16'h0, timer_count_q);
    chk("overflow flag", 16'h1, {15'h0, count_overflow_flag_q});
    @(negedge clk);
    chk("overflow request", 16'h1, {15'h0, overflow_irq_q});
    // write against a running tick
    v = 16'($urandom);
    timer_tick = 1'b1;
    u_cpu.wr16(3'h0, v, 0);
    timer_tick = 1'b0;
    chk("write over tick", v, timer_count_q);
    // dual slope: turn at the 8-bit ceiling, overflow at zero
    waveform_mode_select = 4'h1;
    u_cpu.wr16(3'h0, 16'h00fd, 0);
    overflow_flag_clear = 1'b1;
    timer_tick = 1'b1;
    repeat (4) @(negedge clk);
    overflow_flag_clear = 1'b0;
    timer_tick = 1'b0;
    chk("dual slope turn", 16'h00fd, timer_count_q);
    chk("overflow cleared", 16'h0, {15'h0, count_overflow_flag_q});
    u_cpu.wr16(3'h0, 16'h0002, 0);
    timer_tick = 1'b1;
    repeat (3) @(negedge clk);
    timer_tick = 1'b0;
    chk("dual slope bottom", 16'h0001, timer_count_q);
    chk("bottom overflow", 16'h1, {15'h0, count_overflow_flag_q});
    overflow_irq_ack = 1'b1;
    @(negedge clk);
    overflow_irq_ack = 1'b0;
    chk("overflow serviced", 16'h0, {15'h0, count_overflow_flag_q});
    // ceiling flag per fixed mode
    clock_source_select = 3'h0;
    for (int i = 0; i < 4; i++) begin
      waveform_mode_select = modes[i];
      u_cpu.wr16(3'h0, top_of(modes[i]), 0);
      @(negedge clk);
      chk("top flag", 16'h1, {15'h0, count_top_q});
      u_cpu.wr8(3'h0, 8'hfe);
      @(negedge clk);
      chk("below top", 16'h0, {15'h0, count_top_q});
    end
    // one held upper byte for all words
    waveform_mode_select = 4'h0;
    u_cpu.wr16(3'h4, 16'h12ab, 1);
    u_cpu.wr8(3'h0, 8'h34);
    chk("held upper reuse", 16'h1234, timer_count_q);
    u_cpu.rd16(3'h4, r);
    chk("compare a read", 16'h12ab, r);
    u_cpu.rd16(3'h6, r);
    chk("unmapped read", 16'h0, r);
    // pin capture, request and service
    capture_edge_rising = 1'b1;
    capture_irq_enable = 1'b1;
    lat(n0);
    chk("capture value", 16'h1234, capture_value_q);
    @(negedge clk);
    chk("capture request", 16'h1, {15'h0, capture_irq_q});
    u_cpu.rd16(3'h2, r);
    chk("capture read", 16'h1234, r);
    capture_irq_ack = 1'b1;
    @(negedge clk);
    capture_irq_ack = 1'b0;
    @(negedge clk);
    chk("flag after service", 16'h0, {15'h0, capture_event_flag_q});
    // filter delay and a short glitch
    capture_noise_filter_enable = 1'b1;
    lat(n1);
    chk("filter delay", 16'(n0 + 4), 16'(n1));
    capture_input_pin = 1'b0;
    repeat (6) @(negedge clk);
    clr();
    capture_input_pin = 1'b1;
    repeat (3) @(negedge clk);
    capture_input_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk("glitch dropped", 16'h0, {15'h0, capture_event_flag_q});
    // falling edge select
    capture_noise_filter_enable = 1'b0;
    capture_edge_rising = 1'b0;
    capture_input_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk("rise ignored", 16'h0, {15'h0, capture_event_flag_q});
    capture_input_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk("fall captured", 16'h1, {15'h0, capture_event_flag_q});
    // comparator as source
    comparator_capture_select = 1'b1;
    comparator_output = 1'b1;
    repeat (4) @(negedge clk);
    clr();
    capture_input_pin = 1'b1;
    repeat (4) @(negedge clk);
    capture_input_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk("pin ignored", 16'h0, {15'h0, capture_event_flag_q});
    comparator_output = 1'b0;
    repeat (4) @(negedge clk);
    chk("comparator capture", 16'h1, {15'h0, capture_event_flag_q});
    // capture register as ceiling
    waveform_mode_select = 4'hc;
    clr();
    u_cpu.wr16(3'h2, 16'h5a5a, 0);
    chk("capture write", 16'h5a5a, capture_value_q);
    comparator_output = 1'b1;
    repeat (6) @(negedge clk);
    comparator_output = 1'b0;
    repeat (6) @(negedge clk);
    chk("no capture at ceiling", 16'h0, {15'h0, capture_event_flag_q});
    waveform_mode_select = 4'h0;
    u_cpu.wr16(3'h2, 16'h0f0f, 0);
    chk("capture write refused", 16'h5a5a, capture_value_q);
    tally_and_finish();
  end
endmodule
